// file: core/ttp_pkg.sv
// Package for the eight-bit timer pair: register map, field layouts,
// reset values, counting modes and compare actions.
// Assumes an 8-bit register port with byte addresses.
package ttp_pkg;

  // ==========================================================
  // Widths
  localparam int TTP_DW = 8;
  localparam int TTP_AW = 8;

  // ==========================================================
  // Global register offsets
  localparam logic [7:0] TTP_OFF_TICK = 8'h00;
  localparam logic [7:0] TTP_OFF_FLAGS = 8'h01;
  localparam logic [7:0] TTP_OFF_CPUIRQ = 8'h02;
  localparam logic [7:0] TTP_OFF_IEN = 8'h03;

  // Timer bases (timer 0 at 0x10, timer 1 at 0x20) and local offsets
  localparam logic [7:0] TTP_BASE_T0 = 8'h10;
  localparam logic [7:0] TTP_BASE_T1 = 8'h20;
  localparam logic [3:0] TTP_LOC_CNT = 4'h0;
  localparam logic [3:0] TTP_LOC_CTL = 4'h1;
  localparam logic [3:0] TTP_LOC_CCTL0 = 4'h2;
  localparam logic [3:0] TTP_LOC_CC0 = 4'h3;
  localparam logic [3:0] TTP_LOC_CCTL1 = 4'h4;
  localparam logic [3:0] TTP_LOC_CC1 = 4'h5;

  // ==========================================================
  // Flag register bit positions, per timer t at 3*t + position
  localparam int TTP_FLG_OVF = 0;
  localparam int TTP_FLG_CH0 = 1;
  localparam int TTP_FLG_CH1 = 2;
  localparam int TTP_FLG_PER_TIMER = 3;

  // ==========================================================
  // Counting modes (timer_control[1:0])
  localparam logic [1:0] TTP_MODE_FREE = 2'h0;
  localparam logic [1:0] TTP_MODE_DOWN = 2'h1;
  localparam logic [1:0] TTP_MODE_MOD = 2'h2;
  localparam logic [1:0] TTP_MODE_UPDN = 2'h3;

  // Compare actions (compare control[1:0])
  localparam logic [1:0] TTP_ACT_SET = 2'h0;
  localparam logic [1:0] TTP_ACT_CLR = 2'h1;
  localparam logic [1:0] TTP_ACT_TGL = 2'h2;
  localparam logic [1:0] TTP_ACT_NONE = 2'h3;

  // ==========================================================
  // Reset values and terminal counts
  localparam logic [7:0] TTP_RST_BYTE = 8'h00;
  localparam logic [7:0] TTP_CNT_TOP = 8'hFF;
  localparam logic [7:0] TTP_CNT_ZERO = 8'h00;
  localparam logic [2:0] TTP_RST_TICK = 3'h0;

  // ==========================================================
  // Register layouts
  // timer_control: [7:5] prescale, [4] start, [3] ovf mask, [2] clear, [1:0] mode
  typedef struct packed {
    logic [2:0] prescale_select;
    logic start;
    logic overflow_irq_mask;
    logic counter_clear;
    logic [1:0] mode;
  } ttp_ctl_t;

  // Compare control: [2] irq mask, [1:0] action
  typedef struct packed {
    logic irq_mask;
    logic [1:0] action;
  } ttp_cctl_t;

  // Per-timer events of one clock cycle
  typedef struct packed {
    logic cmp1;
    logic cmp0;
    logic ovf;
  } ttp_evt_t;

  localparam ttp_ctl_t TTP_RST_CTL = '0;
  localparam ttp_cctl_t TTP_RST_CCTL = '0;

endpackage

// file: core/ttp_prescaler.sv
// Power-of-two tick divider: passes one of every 2**select input ticks.
// Assumes tick_in is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
module ttp_prescaler
  import ttp_pkg::*;
#(
  parameter int W = 7
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [2:0] select,
  input wire logic tick_in,
  output logic tick_out
);

  logic [W-1:0] count;
  wire [W-1:0] mask = W'((8'h01 << select) - 8'h01);
  wire advance = enable && tick_in;
  wire hit = advance && ((count & mask) == mask);

  // Count is held while disabled so a halted timer ignores ticks
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      if (advance)
        count <= count + W'(1);
      tick_out <= hit;
    end
  end

endmodule

// file: core/ttp_timer_pair.sv
// Two 8-bit timers with prescaler, four counting modes and two compare
// channels each, with flags, masked CPU requests and DMA triggers.
// Assumes a one-cycle register port on clk_sys; read data the next cycle.
//
// Behaviour
// - each timer has 8-bit up/down counter
// - tick from system, prescaled by 1..128
// - counter value readable through counter register
// - writing one to clear resets counter
// - writing start one begins counting
// - writing start zero halts, keeps value
// - free-running counts up from 0x00
// - free-running wraps 0xFF to 0x00
// - free-running sets overflow flag at 0xFF
// - CPU flag on overflow only if masked-in
// - request needs overflow mask and timer enable; here a compare event with its channel irq mask also raises it
// - two compare channels, one pin each
// - compare sets, clears or toggles pin
// - free, modulo, down and up/down modes
// - interrupts on compare and terminal count
// - modulo counts to compare zero, wraps
// - down loads compare zero, stops at zero
// - up/down counts up then down, repeats
// - every compare gives own DMA pulse
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module ttp_timer_pair
  import ttp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [TTP_AW-1:0] reg_addr,
  input wire logic [TTP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [TTP_DW-1:0] reg_rdata,
  output logic [3:0] cmp_out,
  output logic [3:0] dma_trig,
  output logic [1:0] irq_req
);

  // ==========================================================
  // Address decode
  wire [3:0] loc = reg_addr[3:0];
  // The two timer pages and the four global registers at 0x00-0x03 decode; the rest of the map reads zero
  wire t0_page = (reg_addr[7:4] == TTP_BASE_T0[7:4]);
  wire t1_page = (reg_addr[7:4] == TTP_BASE_T1[7:4]);
  wire t_hit = t0_page || t1_page;
  wire t_sel = reg_addr[5];
  wire wr_tick = reg_wr && (reg_addr == TTP_OFF_TICK);
  wire wr_flags = reg_wr && (reg_addr == TTP_OFF_FLAGS);
  wire wr_cpuirq = reg_wr && (reg_addr == TTP_OFF_CPUIRQ);
  wire wr_ien = reg_wr && (reg_addr == TTP_OFF_IEN);

  // ==========================================================
  // Global state
  logic [2:0] tick_speed_select;
  logic [5:0] timer_irq_flags;
  logic [1:0] timer_cpu_irq_flag;
  logic [1:0] timer_irq_enable;
  logic sys_tick;

  // Per-timer state
  ttp_ctl_t ctl [2];
  ttp_cctl_t cctl0 [2];
  ttp_cctl_t cctl1 [2];
  logic [7:0] cnt [2];
  logic [7:0] cc0_buf [2];
  logic [7:0] cc0 [2];
  logic [7:0] cc1 [2];
  ttp_evt_t evt [2];
  logic [1:0] masked_evt;

  // ==========================================================
  // System tick divider
  ttp_prescaler #(.W(7)) u_tick_div
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(1'b1),
    .select(tick_speed_select),
    .tick_in(1'b1),
    .tick_out(sys_tick)
  );

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tick_speed_select <= TTP_RST_TICK;
    else if (wr_tick)
      tick_speed_select <= reg_wdata[2:0];
  end

  // ==========================================================
  // Timers
  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_timer
      wire sel_me = t_hit && (t_sel == 1'(t));
      wire wr_ctl = reg_wr && sel_me && (loc == TTP_LOC_CTL);
      wire wr_cctl0 = reg_wr && sel_me && (loc == TTP_LOC_CCTL0);
      wire wr_cc0 = reg_wr && sel_me && (loc == TTP_LOC_CC0);
      wire wr_cctl1 = reg_wr && sel_me && (loc == TTP_LOC_CCTL1);
      wire wr_cc1 = reg_wr && sel_me && (loc == TTP_LOC_CC1);
      ttp_ctl_t wctl;
      assign wctl = ttp_ctl_t'(reg_wdata);

      logic dir_up;
      logic tick_raw;
      logic [1:0] pin;

      // Prescaler runs only while started
      ttp_prescaler #(.W(7)) u_div
      (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(ctl[t].start),
        .select(ctl[t].prescale_select),
        .tick_in(sys_tick),
        .tick_out(tick_raw)
      );
      // A tick already in flight when start drops must not move the count
      wire tick = tick_raw && ctl[t].start;

      // Next counter value per mode
      wire [7:0] c = cnt[t];
      wire at_zero = (c == TTP_CNT_ZERO);
      wire at_top = (c == cc0[t]);
      wire [7:0] inc = c + 8'h01;
      wire [7:0] dec = c - 8'h01;
      wire [1:0] mode = ctl[t].mode;
      wire turn_down = at_top && !at_zero;
      wire [7:0] nx_free = inc;
      wire [7:0] nx_mod = at_top ? TTP_CNT_ZERO : inc;
      wire [7:0] nx_down = at_zero ? TTP_CNT_ZERO : dec;
      wire [7:0] nx_ud = dir_up ? (turn_down ? dec : inc) : (at_zero ? inc : dec);
      wire [7:0] next_cnt = (mode == TTP_MODE_FREE) ? nx_free :
                            (mode == TTP_MODE_MOD) ? nx_mod :
                            (mode == TTP_MODE_DOWN) ? nx_down : nx_ud;
      wire next_dir = dir_up ? !turn_down : at_zero;

      // Terminal-count and compare events
      wire ovf_free = (next_cnt == TTP_CNT_TOP);
      wire ovf_mod = (next_cnt == cc0[t]);
      wire ovf_zero = (next_cnt == TTP_CNT_ZERO) && !at_zero;
      wire ovf_hit = (mode == TTP_MODE_FREE) ? ovf_free :
                     (mode == TTP_MODE_MOD) ? ovf_mod : ovf_zero;
      wire cmp0_hit = (mode == TTP_MODE_UPDN) ? ovf_zero : (next_cnt == cc0[t]);
      wire cmp1_hit = (next_cnt == cc1[t]);
      assign evt[t].ovf = tick && ovf_hit;
      assign evt[t].cmp0 = tick && cmp0_hit;
      assign evt[t].cmp1 = tick && cmp1_hit;
      wire start_rise = wr_ctl && wctl.start && !ctl[t].start;
      // Clear beats the down-mode load, which beats a tick
      wire do_clear = wr_ctl && wctl.counter_clear;
      wire do_load = start_rise && (wctl.mode == TTP_MODE_DOWN);

      // Control and compare registers
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          ctl[t] <= TTP_RST_CTL;
          cctl0[t] <= TTP_RST_CCTL;
          cctl1[t] <= TTP_RST_CCTL;
          cc0_buf[t] <= TTP_RST_BYTE;
          cc1[t] <= TTP_RST_BYTE;
        end
        else
        begin
          if (wr_ctl)
            ctl[t] <= {wctl[7:3], 1'b0, wctl[1:0]};
          if (wr_cctl0)
            cctl0[t] <= reg_wdata[2:0];
          if (wr_cctl1)
            cctl1[t] <= reg_wdata[2:0];
          if (wr_cc0)
            cc0_buf[t] <= reg_wdata;
          if (wr_cc1)
            cc1[t] <= reg_wdata;
        end
      end

      // Counter; compare value 0 is taken over only at count zero
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          cnt[t] <= TTP_RST_BYTE;
          dir_up <= 1'b1;
          cc0[t] <= TTP_RST_BYTE;
        end
        else
        begin
          if (at_zero)
            cc0[t] <= cc0_buf[t];
          if (do_clear)
          begin
            cnt[t] <= TTP_CNT_ZERO;
            dir_up <= 1'b1;
          end
          else if (do_load)
            cnt[t] <= cc0_buf[t];
          else if (tick)
          begin
            cnt[t] <= next_cnt;
            dir_up <= next_dir;
          end
        end
      end

      // Compare pins and DMA triggers
      function automatic logic apply(input logic [1:0] act, input logic cur);
        case (act)
          TTP_ACT_SET: apply = 1'b1;
          TTP_ACT_CLR: apply = 1'b0;
          TTP_ACT_TGL: apply = !cur;
          default: apply = cur;
        endcase
      endfunction

      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          pin <= 2'b00;
          dma_trig[2*t +: 2] <= 2'b00;
        end
        else
        begin
          if (evt[t].cmp0)
            pin[0] <= apply(cctl0[t].action, pin[0]);
          if (evt[t].cmp1)
            pin[1] <= apply(cctl1[t].action, pin[1]);
          dma_trig[2*t +: 2] <= {evt[t].cmp1, evt[t].cmp0};
        end
      end
      assign cmp_out[2*t +: 2] = pin;

      // Overflow gated by its mask; compares by their channel masks
      assign masked_evt[t] = (evt[t].ovf && ctl[t].overflow_irq_mask) ||
                             (evt[t].cmp0 && cctl0[t].irq_mask) ||
                             (evt[t].cmp1 && cctl1[t].irq_mask);
    end
  endgenerate

  // ==========================================================
  // Flags: software writes zero to clear, a same-cycle event wins
  wire [5:0] flag_set = {evt[1], evt[0]};
  wire [5:0] flag_keep = wr_flags ? (timer_irq_flags & reg_wdata[5:0]) : timer_irq_flags;
  wire [5:0] next_flags = flag_keep | flag_set;
  wire [1:0] cpu_keep = wr_cpuirq ? (timer_cpu_irq_flag & reg_wdata[1:0]) : timer_cpu_irq_flag;
  wire [1:0] next_cpu = cpu_keep | masked_evt;
  wire [1:0] next_irq = timer_cpu_irq_flag & timer_irq_enable;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_irq_flags <= '0;
      timer_cpu_irq_flag <= '0;
      timer_irq_enable <= '0;
      irq_req <= '0;
    end
    else
    begin
      timer_irq_flags <= next_flags;
      timer_cpu_irq_flag <= next_cpu;
      if (wr_ien)
        timer_irq_enable <= reg_wdata[1:0];
      irq_req <= next_irq;
    end
  end

  // ==========================================================
  // Read path
  wire [7:0] t_cnt = cnt[t_sel];
  wire [7:0] t_ctl = ctl[t_sel];
  wire [7:0] t_cctl0 = {5'h00, cctl0[t_sel]};
  wire [7:0] t_cctl1 = {5'h00, cctl1[t_sel]};
  wire [7:0] t_word = (loc == TTP_LOC_CNT) ? t_cnt :
                      (loc == TTP_LOC_CTL) ? t_ctl :
                      (loc == TTP_LOC_CCTL0) ? t_cctl0 :
                      (loc == TTP_LOC_CC0) ? cc0_buf[t_sel] :
                      (loc == TTP_LOC_CCTL1) ? t_cctl1 :
                      (loc == TTP_LOC_CC1) ? cc1[t_sel] : 8'h00;
  wire [7:0] g_word = (reg_addr == TTP_OFF_TICK) ? {5'h00, tick_speed_select} :
                      (reg_addr == TTP_OFF_FLAGS) ? {2'h0, timer_irq_flags} :
                      (reg_addr == TTP_OFF_CPUIRQ) ? {6'h00, timer_cpu_irq_flag} :
                      (reg_addr == TTP_OFF_IEN) ? {6'h00, timer_irq_enable} : 8'h00;
  wire [7:0] rd_word = t_hit ? t_word : g_word;
  wire [7:0] next_rdata = reg_rd ? rd_word : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= TTP_RST_BYTE;
    else
      reg_rdata <= next_rdata;
  end

endmodule

// file: verification/ttp_timer_pair_chk.sv
// Checker for the timer pair: read timing, pin events, request gating, halted timer 0.
// Bound to ttp_timer_pair; sees only its ports.
`timescale 1ns/100ps
module ttp_timer_pair_chk
  import ttp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [TTP_AW-1:0] reg_addr,
  input wire logic [TTP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [TTP_DW-1:0] reg_rdata,
  input wire logic [3:0] cmp_out,
  input wire logic [3:0] dma_trig,
  input wire logic [1:0] irq_req
);
  // ====
  // Helper state
  logic [1:0] ien;
  logic t0_run;
  logic [2:0] t0_age;
  wire t0_rd = reg_rd && (reg_addr == 8'h10);
  wire t0_quiet = !t0_run && (t0_age == 3'h6);
  wire t0_wr = reg_wr && (reg_addr[7:4] == 4'h1);
  wire [2:0] next_t0_age = t0_wr ? 3'h0 : t0_age + {2'h0, t0_age != 3'h6};
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ien <= 2'h0;
      t0_run <= 1'b0;
      t0_age <= 3'h0;
    end
    else
    begin
      t0_age <= next_t0_age;
      if (reg_wr && reg_addr == 8'h03)
        ien <= reg_wdata[1:0];
      if (reg_wr && reg_addr == 8'h11)
        t0_run <= reg_wdata[4];
    end
  end
  // ====
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  read_unmapped_a: assert property (reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  clr_reads_a: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata[2] == 1'b0)
    else $error("clear bit reads back one");
  clear_zero_a: assert property (reg_wr && reg_addr == 8'h11 && reg_wdata == 8'h04 && !t0_run
    ##2 t0_rd |=> reg_rdata == 8'h00) else $error("counter not zero after clear");
  halt_hold_a: assert property (t0_quiet && t0_rd ##2 t0_quiet && t0_rd
    |=> reg_rdata == $past(reg_rdata, 2)) else $error("halted counter moved");
  halt_quiet_a: assert property (t0_quiet |-> dma_trig[1:0] == 2'b00 && $stable(cmp_out[1:0]))
    else $error("halted timer made an event");
  pin_event_a: assert property (((cmp_out ^ $past(cmp_out)) & ~dma_trig) == 4'h0)
    else $error("pin changed without trigger");
  irq_gate_a: assert property ((irq_req & ~$past(ien)) == 2'b00)
    else $error("request without enable");
  irq_off_a: assert property (reg_wr && reg_addr == 8'h03 && reg_wdata[1:0] == 2'b00
    |-> ##2 irq_req == 2'b00) else $error("request stayed after disable");
  cover property (t0_quiet && t0_rd);
  cover property (dma_trig[2]);
  cover property (irq_req[0]);
endmodule
bind ttp_timer_pair ttp_timer_pair_chk chk (.clk_sys(clk_sys), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cmp_out(cmp_out), .dma_trig(dma_trig), .irq_req(irq_req));

// file: verification/tb.sv
// Self-checking bench for the timer pair over its register port.
// Assumes the package map: timer 0 at 0x10, timer 1 at 0x20, globals at 0x00.
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] cmp_out;
  logic [3:0] dma_trig;
  logic [1:0] irq_req;
  int bad_count = 0;
  int check_count = 0;
  int mx;
  int ups;
  int dns;
  int odd;
  int wraps;
  int pulses;
  logic [7:0] v;
  logic [7:0] w;
  always #5 clk_sys = ~clk_sys;
  ttp_timer_pair uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_out(cmp_out), .dma_trig(dma_trig), .irq_req(irq_req));
  // ====
  // Bus and compare tasks
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  // Back-to-back reads of one counter, stepping statistics
  task automatic burst(input logic [7:0] a, input int n);
    logic [7:0] p;
    mx = 0;
    ups = 0;
    dns = 0;
    odd = 0;
    wraps = 0;
    pulses = 0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    #1 p = reg_rdata;
    for (int i = 1; i < n; i++)
    begin
      @(posedge clk_sys);
      if (i == n - 1)
        reg_rd <= 1'b0;
      #1 v = reg_rdata;
      pulses += dma_trig[2];
      if (v > mx)
        mx = v;
      if (p == 8'hFF && v == 8'h00)
        wraps++;
      if (v == p + 8'h01)
        ups++;
      else if (v == p - 8'h01)
        dns++;
      else if (v != p)
        odd++;
      p = v;
    end
    @(posedge clk_sys);
  endtask
  // ====
  // Scenarios
  task automatic t_free();
    rd(8'h10, v);
    chk8("cnt", 8'h00, v);
    rd(8'hFF, v);
    chk8("unmapped", 8'h00, v);
    wr(8'h11, 8'h10);
    burst(8'h10, 300);
    chk8("free odd", 8'h00, 8'(odd));
    chk8("free max", 8'hFF, 8'(mx));
    chk8("free wrap", 8'h01, {7'h0, wraps > 0});
    rd(8'h01, v);
    chk8("ovf0", 8'h01, v & 8'h01);
    wr(8'h11, 8'h00);
    repeat (6) @(posedge clk_sys);
    rd(8'h10, v);
    rd(8'h10, w);
    chk8("halt", v, w);
    wr(8'h11, 8'h04);
    rd(8'h10, v);
    chk8("clear", 8'h00, v);
    rd(8'h11, v);
    chk8("clear bit", 8'h00, v & 8'h04);
    wr(8'h31, 8'h10);
    rd(8'h21, v);
    chk8("gap write", 8'h00, v);
  endtask
  task automatic t_pre();
    wr(8'h11, 8'hF0);
    repeat (1024) @(posedge clk_sys);
    wr(8'h11, 8'hE0);
    rd(8'h10, v);
    chk8("div128", 8'h01, {7'h0, v >= 8'h07 && v <= 8'h09});
    repeat (300) @(posedge clk_sys);
    rd(8'h10, w);
    chk8("held", v, w);
    wr(8'h11, 8'h04);
    wr(8'h00, 8'h01);
    rd(8'h00, v);
    chk8("tick sel", 8'h01, v);
    wr(8'h11, 8'h10);
    repeat (64) @(posedge clk_sys);
    wr(8'h11, 8'h00);
    rd(8'h10, v);
    chk8("tick half", 8'h01, {7'h0, v >= 8'h1E && v <= 8'h23});
    wr(8'h00, 8'h00);
    wr(8'h11, 8'h04);
  endtask
  task automatic t_mod();
    wr(8'h23, 8'h05);
    wr(8'h22, 8'h02);
    wr(8'h21, 8'h12);
    burst(8'h20, 120);
    chk8("mod max", 8'h05, 8'(mx));
    chk8("dma", 8'h01, {7'h0, pulses >= 19 && pulses <= 21});
    rd(8'h01, v);
    chk8("t1 flags", 8'h18, v & 8'h18);
    wr(8'h21, 8'h00);
    wr(8'h21, 8'h04);
    wr(8'h23, 8'h04);
    wr(8'h21, 8'h13);
    burst(8'h20, 60);
    chk8("ud max", 8'h04, 8'(mx));
    chk8("ud odd", 8'h00, 8'(odd));
    chk8("ud down", 8'h01, {7'h0, dns > 0});
    wr(8'h21, 8'h00);
  endtask
  task automatic t_down();
    wr(8'h01, 8'h00);
    wr(8'h13, 8'h09);
    wr(8'h11, 8'h11);
    burst(8'h10, 40);
    chk8("dn ups", 8'h00, 8'(ups));
    chk8("dn end", 8'h00, v);
    chk8("dn max", 8'h01, {7'h0, mx <= 9 && dns > 0});
    rd(8'h01, v);
    chk8("dn ovf", 8'h01, v & 8'h01);
    wr(8'h11, 8'h04);
  endtask
  task automatic t_cmp();
    wr(8'h15, 8'h03);
    for (int a = 0; a < 2; a++)
    begin
      wr(8'h14, {7'h0, a == 0});
      wr(8'h11, 8'h10);
      repeat (300) @(posedge clk_sys);
      wr(8'h11, 8'h00);
      #1 chk8("pin", {7'h0, a == 1}, {7'h0, cmp_out[1]});
      @(posedge clk_sys);
    end
  endtask
  task automatic t_irq();
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h11, m == 0 ? 8'h10 : 8'h18);
      repeat (300) @(posedge clk_sys);
      rd(8'h02, v);
      chk8("cpu flag", 8'(m), v & 8'h01);
      #1 chk8("irq", 8'(m), {7'h0, irq_req[0]});
      @(posedge clk_sys);
    end
    wr(8'h03, 8'h00);
    #1 chk8("irq off", 8'h00, {7'h0, irq_req[0]});
    @(posedge clk_sys);
    wr(8'h11, 8'h00);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_free();
    t_pre();
    t_mod();
    t_down();
    t_cmp();
    t_irq();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
endmodule
